// ---- hdl/tbsfs_sequencer.sv ----
// power-state and fault sequencer for a triple buck regulator
// Function
// - power-up: startup, bucks off, supply-good low
// - enable low forces startup state, except in shutdown
// - startup sequence runs, then active
// - reset command in startup restarts sequence
// - active: all bucks on, supply-good high
// - active to startup on enable low/reset
// - active to sleep on sleep command
// - active or sleep to shutdown on command
// - sleep: only buck 1 off, good high
// - wake-up returns active, reloads default voltages
// - sleep to startup on enable low/reset
// - shutdown: bucks off, supply-good low
// - shutdown exits on enable rising/reset
// - undervolt lockout holds reset, then startup
// - ready lost over 1ms: hiccup 200ms
// - not ready within 8ms: hiccup 200ms
// - over-temperature holds reset, then startup
// - over-temperature: tri-state, good low
// - lockout: tri-state, feedback pulldown, good low
// - bucks switch on 120 degrees apart
`timescale 1ns/10ps
`include "tbsfs_defines.svh"
module tbsfs_sequencer #(
   parameter int READY_LOSS_CYC = `TBSFS_READY_LOSS_CYC,
   parameter int START_TMO_CYC  = `TBSFS_START_TMO_CYC,
   parameter int HICCUP_CYC     = `TBSFS_HICCUP_CYC,
   parameter int STAGGER_CYC    = `TBSFS_STAGGER_CYC
) (
   input  wire logic                ref_clk,
   input  wire logic                rst_n,
   input  wire logic                enable_pin,
   input  wire logic                undervolt_lockout,
   input  wire logic                over_temp,
   input  wire logic [2:0]          buck_ready,
   input  wire tbsfs_pkg::tbsfs_cmd_t cmd,
   output tbsfs_pkg::tbsfs_out_t    ctrl,
   output logic [2:0]               phase_start,
   output tbsfs_pkg::tbsfs_state_t  state
);
   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic [5:0] sync1_r;
   logic [5:0] sync2_r;
   logic       en_s;
   logic       uv_s;
   logic       ot_s;
   logic [2:0] rdy_s;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync1_r <= 6'h00;
         sync2_r <= 6'h00;
      end
      else
      begin
         sync1_r <= {enable_pin, undervolt_lockout, over_temp, buck_ready};
         sync2_r <= sync1_r;
      end
   end

   assign en_s  = sync2_r[5];
   assign uv_s  = sync2_r[4];
   assign ot_s  = sync2_r[3];
   assign rdy_s = sync2_r[2:0];

   // ----------------------------------------------------------------
   // state machine
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {SQ_IDLE, SQ_RAMP, SQ_WAIT_RDY, SQ_RUN, SQ_HICCUP} tbsfs_seq_t;

   localparam int TW = $clog2(HICCUP_CYC + 1);

   tbsfs_pkg::tbsfs_state_t st_r;
   tbsfs_pkg::tbsfs_state_t st_nxt;
   tbsfs_seq_t              sq_r;
   tbsfs_seq_t              sq_nxt;
   logic [TW-1:0]           tmr_r;
   logic [TW-1:0]           tmr_nxt;
   logic [TW-1:0]           loss_r;
   logic [TW-1:0]           loss_nxt;
   logic [1:0]              nen_r;
   logic [1:0]              nen_nxt;
   logic [2:0]              en_r;
   logic [2:0]              en_nxt;
   logic [2:0]              hiz_r;
   logic [2:0]              hiz_nxt;
   logic                    pd_r;
   logic                    pd_nxt;
   logic                    good_r;
   logic                    good_nxt;
   logic                    dflt_r;
   logic                    dflt_nxt;
   logic                    fault_hold;
   logic                    cmd_ok;
   logic                    rdy_ok;

   function automatic logic [TW-1:0] cyc(input int n);
      cyc = TW'(n);
   endfunction : cyc

   function automatic logic all_ready(input logic [2:0] en, input logic [2:0] rdy);
      all_ready = ((en & rdy) == en);
   endfunction : all_ready

   assign fault_hold = uv_s | ot_s;
   assign cmd_ok     = en_s;
   assign rdy_ok     = all_ready(en_r, rdy_s);

   always_comb
   begin
      st_nxt   = st_r;
      sq_nxt   = sq_r;
      tmr_nxt  = (tmr_r != '0) ? tmr_r - cyc(1) : tmr_r;
      loss_nxt = loss_r;
      nen_nxt  = nen_r;
      en_nxt   = en_r;
      hiz_nxt  = 3'h0;
      pd_nxt   = 1'b0;
      good_nxt = good_r;
      dflt_nxt = 1'b0;
      if (fault_hold)
      begin
         // internal logic held in reset, outputs tri-stated
         st_nxt   = tbsfs_pkg::TBSFS_ST_STARTUP;
         sq_nxt   = SQ_IDLE;
         en_nxt   = 3'h0;
         hiz_nxt  = 3'h7;
         pd_nxt   = uv_s;
         good_nxt = 1'b0;
         tmr_nxt  = '0;
         loss_nxt = '0;
         nen_nxt  = 2'h0;
      end
      else if (!en_s && st_r != tbsfs_pkg::TBSFS_ST_STARTUP &&
               st_r != tbsfs_pkg::TBSFS_ST_SHUTDOWN)
      begin
         st_nxt   = tbsfs_pkg::TBSFS_ST_STARTUP;
         sq_nxt   = SQ_IDLE;
         en_nxt   = 3'h0;
         good_nxt = 1'b0;
      end
      else
      begin
         unique case (st_r)
            tbsfs_pkg::TBSFS_ST_STARTUP:
            begin
               if (cmd_ok && cmd.reset_cmd)
               begin
                  sq_nxt   = SQ_IDLE;
                  en_nxt   = 3'h0;
                  good_nxt = 1'b0;
               end
               else if (en_s)
               begin
                  unique case (sq_r)
                     SQ_IDLE:
                     begin
                        en_nxt  = 3'h1;
                        nen_nxt = 2'h1;
                        tmr_nxt = cyc(STAGGER_CYC);
                        sq_nxt  = SQ_RAMP;
                        dflt_nxt = 1'b1;
                     end
                     SQ_RAMP:
                     begin
                        if (tmr_r == '0)
                        begin
                           if (nen_r == 2'h3)
                           begin
                              tmr_nxt = cyc(START_TMO_CYC);
                              sq_nxt  = SQ_WAIT_RDY;
                           end
                           else
                           begin
                              en_nxt  = {en_r[1:0], 1'b1};
                              nen_nxt = nen_r + 2'h1;
                              tmr_nxt = cyc(STAGGER_CYC);
                           end
                        end
                     end
                     SQ_WAIT_RDY:
                     begin
                        if (rdy_ok)
                        begin
                           good_nxt = 1'b1;
                           st_nxt   = tbsfs_pkg::TBSFS_ST_ACTIVE;
                           sq_nxt   = SQ_RUN;
                           loss_nxt = '0;
                        end
                        else if (tmr_r == '0)
                        begin
                           en_nxt  = 3'h0;
                           tmr_nxt = cyc(HICCUP_CYC);
                           sq_nxt  = SQ_HICCUP;
                        end
                     end
                     SQ_HICCUP:
                     begin
                        if (tmr_r == '0)
                           sq_nxt = SQ_IDLE;
                     end
                     SQ_RUN:
                        sq_nxt = SQ_IDLE;
                  endcase
               end
               else
               begin
                  st_nxt   = tbsfs_pkg::TBSFS_ST_STARTUP;
                  sq_nxt   = SQ_IDLE;
                  en_nxt   = 3'h0;
                  good_nxt = 1'b0;
               end
            end
            tbsfs_pkg::TBSFS_ST_ACTIVE, tbsfs_pkg::TBSFS_ST_SLEEP:
            begin
               // ready-loss watch on enabled bucks
               if (!rdy_ok)
                  loss_nxt = (loss_r == cyc(READY_LOSS_CYC)) ? loss_r : loss_r + cyc(1);
               else
                  loss_nxt = '0;
               if (!rdy_ok && loss_r == cyc(READY_LOSS_CYC))
               begin
                  st_nxt   = tbsfs_pkg::TBSFS_ST_STARTUP;
                  sq_nxt   = SQ_HICCUP;
                  en_nxt   = 3'h0;
                  good_nxt = 1'b0;
                  tmr_nxt  = cyc(HICCUP_CYC);
               end
               else if (cmd_ok && cmd.reset_cmd)
               begin
                  st_nxt   = tbsfs_pkg::TBSFS_ST_STARTUP;
                  sq_nxt   = SQ_IDLE;
                  en_nxt   = 3'h0;
                  good_nxt = 1'b0;
               end
               else if (cmd_ok && cmd.shutdown_cmd)
               begin
                  st_nxt   = tbsfs_pkg::TBSFS_ST_SHUTDOWN;
                  en_nxt   = 3'h0;
                  good_nxt = 1'b0;
               end
               else if (st_r == tbsfs_pkg::TBSFS_ST_ACTIVE && cmd_ok && cmd.sleep_cmd)
               begin
                  st_nxt   = tbsfs_pkg::TBSFS_ST_SLEEP;
                  en_nxt   = 3'h6;
                  loss_nxt = '0;
               end
               else if (st_r == tbsfs_pkg::TBSFS_ST_SLEEP && cmd_ok && cmd.wake_cmd)
               begin
                  st_nxt   = tbsfs_pkg::TBSFS_ST_ACTIVE;
                  en_nxt   = 3'h7;
                  dflt_nxt = 1'b1;
                  loss_nxt = '0;
               end
            end
            tbsfs_pkg::TBSFS_ST_SHUTDOWN:
            begin
               en_nxt   = 3'h0;
               good_nxt = 1'b0;
               // exit on enable rising or reset command
               if ((en_s && !nen_r[1]) || (cmd_ok && cmd.reset_cmd))
               begin
                  st_nxt = tbsfs_pkg::TBSFS_ST_STARTUP;
                  sq_nxt = SQ_IDLE;
               end
               nen_nxt = {en_s, 1'b0};
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r   <= tbsfs_pkg::TBSFS_ST_STARTUP;
         sq_r   <= SQ_IDLE;
         tmr_r  <= '0;
         loss_r <= '0;
         nen_r  <= 2'h0;
         en_r   <= 3'h0;
         hiz_r  <= 3'h0;
         pd_r   <= 1'b0;
         good_r <= 1'b0;
         dflt_r <= 1'b0;
      end
      else
      begin
         st_r   <= st_nxt;
         sq_r   <= sq_nxt;
         tmr_r  <= tmr_nxt;
         loss_r <= loss_nxt;
         nen_r  <= nen_nxt;
         en_r   <= en_nxt;
         hiz_r  <= hiz_nxt;
         pd_r   <= pd_nxt;
         good_r <= good_nxt;
         dflt_r <= dflt_nxt;
      end
   end

   assign ctrl.buck_en       = en_r;
   assign ctrl.sw_hiz        = hiz_r;
   assign ctrl.fb_pulldown   = pd_r;
   assign ctrl.supply_good   = good_r;
   assign ctrl.load_defaults = dflt_r;
   assign state              = st_r;

   // ----------------------------------------------------------------
   // phase generator
   // ----------------------------------------------------------------
   tbsfs_phase_gen #(
      .PERIOD (`TBSFS_PHASE_PERIOD)
   ) u_phase (
      .ref_clk     (ref_clk),
      .rst_n       (rst_n),
      .phase_start (phase_start)
   );
endmodule : tbsfs_sequencer

// ---- hdl/tbsfs_defines.svh ----
// timing counts and field positions of the power-state sequencer
`ifndef TBSFS_DEFINES_SVH
`define TBSFS_DEFINES_SVH
`define TBSFS_CLK_MHZ        250
`define TBSFS_READY_LOSS_US  1000
`define TBSFS_START_TMO_US   8000
`define TBSFS_HICCUP_US      200000
`define TBSFS_STAGGER_US     100
`define TBSFS_READY_LOSS_CYC (`TBSFS_READY_LOSS_US * `TBSFS_CLK_MHZ)
`define TBSFS_START_TMO_CYC  (`TBSFS_START_TMO_US * `TBSFS_CLK_MHZ)
`define TBSFS_HICCUP_CYC     (`TBSFS_HICCUP_US * `TBSFS_CLK_MHZ)
`define TBSFS_STAGGER_CYC    (`TBSFS_STAGGER_US * `TBSFS_CLK_MHZ)
`define TBSFS_PHASE_PERIOD   125
`define TBSFS_BUCK1          0
`define TBSFS_NBUCK          3
`endif

// ---- hdl/tbsfs_pkg.sv ----
// types of the power-state sequencer
package tbsfs_pkg;
   typedef enum logic [1:0] {TBSFS_ST_STARTUP, TBSFS_ST_ACTIVE, TBSFS_ST_SLEEP,
                             TBSFS_ST_SHUTDOWN} tbsfs_state_t;
   typedef struct packed {
      logic reset_cmd;
      logic sleep_cmd;
      logic wake_cmd;
      logic shutdown_cmd;
   } tbsfs_cmd_t;
   typedef struct packed {
      logic [2:0] buck_en;
      logic [2:0] sw_hiz;
      logic       fb_pulldown;
      logic       supply_good;
      logic       load_defaults;
   } tbsfs_out_t;
endpackage : tbsfs_pkg

// ---- hdl/tbsfs_phase_gen.sv ----
// three-phase switching start pulses spaced by a third of a period
`timescale 1ns/10ps
`include "tbsfs_defines.svh"
module tbsfs_phase_gen #(
   parameter int PERIOD = `TBSFS_PHASE_PERIOD
) (
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   output logic [2:0]      phase_start
);
   localparam int CW = $clog2(PERIOD);
   localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
   localparam logic [CW-1:0] P1   = CW'(PERIOD / 3);
   localparam logic [CW-1:0] P2   = CW'((2 * PERIOD) / 3);

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic [2:0]    ph_r;
   logic [2:0]    ph_nxt;

   always_comb
   begin
      cnt_nxt = (cnt_r == LAST) ? '0 : cnt_r + CW'(1);
      ph_nxt  = {cnt_r == P2, cnt_r == P1, cnt_r == '0};
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_r <= '0;
         ph_r  <= 3'h0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         ph_r  <= ph_nxt;
      end
   end

   assign phase_start = ph_r;
endmodule : tbsfs_phase_gen

// ---- dv/tbsfs_seq_assertions.sv ----
// port-level checks of the power-state sequencer
`timescale 1ns/10ps
module tbsfs_seq_assertions (
   input wire logic                    ref_clk,
   input wire logic                    rst_n,
   input wire logic                    enable_pin,
   input wire logic                    undervolt_lockout,
   input wire logic                    over_temp,
   input wire logic [2:0]              buck_ready,
   input wire tbsfs_pkg::tbsfs_cmd_t   cmd,
   input wire tbsfs_pkg::tbsfs_out_t   ctrl,
   input wire logic [2:0]              phase_start,
   input wire tbsfs_pkg::tbsfs_state_t state
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   logic       in_act;
   logic       in_slp;
   logic       in_sht;
   logic       calm;
   logic [2:0] calm_r;
   logic [2:0] calm_nxt;
   assign in_act = state == tbsfs_pkg::TBSFS_ST_ACTIVE;
   assign in_slp = state == tbsfs_pkg::TBSFS_ST_SLEEP;
   assign in_sht = state == tbsfs_pkg::TBSFS_ST_SHUTDOWN;
   assign calm   = calm_r >= 3'h4;
   // cycles since pins last returned to the quiet level
   always_comb
   begin
      calm_nxt = calm_r;
      if (!enable_pin || undervolt_lockout || over_temp)
         calm_nxt = 3'h0;
      else if (calm_r != 3'h7)
         calm_nxt = calm_r + 3'h1;
   end
   always_ff @(posedge ref_clk or negedge rst_n)
      if (!rst_n)
         calm_r <= 3'h0;
      else
         calm_r <= calm_nxt;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   AST_ACTIVE_OUT: assert property (in_act |-> ctrl.buck_en == 3'h7 && ctrl.supply_good)
      else $error("active outputs wrong");
   AST_SLEEP_OUT: assert property (in_slp |-> ctrl.buck_en == 3'h6 && ctrl.supply_good)
      else $error("sleep outputs wrong");
   AST_SHUT_OUT: assert property (in_sht |-> ctrl.buck_en == 3'h0 && !ctrl.supply_good)
      else $error("shutdown outputs wrong");
   AST_SLEEP_CMD: assert property (in_act && calm && cmd == 4'h4 |=> in_slp)
      else $error("sleep command not taken");
   AST_WAKE_CMD: assert property (in_slp && calm && cmd == 4'h2
      |=> in_act && ctrl.load_defaults)
      else $error("wake command not taken");
   AST_SHUT_CMD: assert property ((in_act || in_slp) && calm && cmd == 4'h1 |=> in_sht)
      else $error("shutdown command not taken");
   AST_RESET_CMD: assert property (calm && cmd == 4'h8
      |=> state == tbsfs_pkg::TBSFS_ST_STARTUP)
      else $error("reset command not taken");
   AST_ENABLE_LOW: assert property ((!enable_pin)[*4] |=> $stable(state) && !in_act)
      else $error("state moved while enable low");
   AST_LOCKOUT: assert property (undervolt_lockout[*5] |-> ctrl.sw_hiz == 3'h7
      && ctrl.fb_pulldown && !ctrl.supply_good && ctrl.buck_en == 3'h0)
      else $error("lockout outputs wrong");
   AST_OVER_TEMP: assert property (over_temp[*5] |-> ctrl.sw_hiz == 3'h7
      && !ctrl.supply_good && state == tbsfs_pkg::TBSFS_ST_STARTUP)
      else $error("over-temperature outputs wrong");
   AST_GOOD_READY: assert property ($rose(ctrl.supply_good) |-> buck_ready == 3'h7
      && ctrl.buck_en == 3'h7)
      else $error("supply good before ready");
   AST_PHASE: assert property (phase_start[0] |-> ##41 phase_start[1] ##42 phase_start[2])
      else $error("phase spacing wrong");
   COV_WAKE: cover property (in_slp ##1 in_act);
   COV_SHUT_EXIT: cover property (in_sht ##1 state == tbsfs_pkg::TBSFS_ST_STARTUP);
   COV_GOOD_LOST: cover property ($fell(ctrl.supply_good) && !in_sht);
endmodule : tbsfs_seq_assertions

bind tbsfs_sequencer tbsfs_seq_assertions tbsfs_seq_assertions_inst (
   .ref_clk           (ref_clk),
   .rst_n             (rst_n),
   .enable_pin        (enable_pin),
   .undervolt_lockout (undervolt_lockout),
   .over_temp         (over_temp),
   .buck_ready        (buck_ready),
   .cmd               (cmd),
   .ctrl              (ctrl),
   .phase_start       (phase_start),
   .state             (state)
);

// ---- dv/tbsfs_host_model.sv ----
// system processor model issuing decoded power-state commands
`timescale 1ns/10ps
module tbsfs_host_model (
   input wire logic              ref_clk,
   output tbsfs_pkg::tbsfs_cmd_t cmd
);
   logic conv_en_r;
   initial
   begin
      cmd = '0;
      conv_en_r = 1'b1;
   end
   // one-cycle pulse: 0 reset, 1 sleep, 2 wake, 3 shutdown
   task automatic issue(input int k);
      if (k == 3)
      begin
         @(posedge ref_clk);
         conv_en_r <= 1'b0;
      end
      @(posedge ref_clk);
      cmd <= 4'h8 >> k;
      @(posedge ref_clk);
      cmd <= '0;
      #1;
   endtask : issue
endmodule : tbsfs_host_model

// ---- dv/testbench.sv ----
// self-checking bench of the power-state sequencer
`timescale 1ns/10ps
module testbench;
   logic                    ref_clk;
   logic                    rst_n;
   logic                    enable_pin;
   logic                    undervolt_lockout;
   logic                    over_temp;
   logic [2:0]              buck_ready;
   tbsfs_pkg::tbsfs_cmd_t   cmd;
   tbsfs_pkg::tbsfs_out_t   ctrl;
   logic [2:0]              phase_start;
   tbsfs_pkg::tbsfs_state_t state;
   int                      n_mismatch;
   int                      n_checks;

   tbsfs_sequencer #(
      .READY_LOSS_CYC (20),
      .START_TMO_CYC  (50),
      .HICCUP_CYC     (100),
      .STAGGER_CYC    (5)
   ) tbsfs_sequencer_inst (
      .ref_clk           (ref_clk),
      .rst_n             (rst_n),
      .enable_pin        (enable_pin),
      .undervolt_lockout (undervolt_lockout),
      .over_temp         (over_temp),
      .buck_ready        (buck_ready),
      .cmd               (cmd),
      .ctrl              (ctrl),
      .phase_start       (phase_start),
      .state             (state)
   );
   tbsfs_host_model tbsfs_host_model_inst (
      .ref_clk (ref_clk),
      .cmd     (cmd)
   );

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : cyc
   task automatic wait_st(input tbsfs_pkg::tbsfs_state_t s, input int n);
      for (int i = 0; i < n && state !== s; i++) cyc(1);
      chk("state", 8'(s), 8'(state));
   endtask : wait_st
   task automatic wait_en(input logic [2:0] e, input int n);
      for (int i = 0; i < n && ctrl.buck_en !== e; i++) cyc(1);
      chk("buck_en", 8'(e), 8'(ctrl.buck_en));
   endtask : wait_en
   task automatic outs(input logic [2:0] e, input logic g);
      chk("buck_en", 8'(e), 8'(ctrl.buck_en));
      chk("supply_good", 8'(g), 8'(ctrl.supply_good));
   endtask : outs
   task automatic pins(input logic en, input logic uv, input logic hot, input logic [2:0] rdy);
      @(posedge ref_clk);
      enable_pin <= en;
      undervolt_lockout <= uv;
      over_temp <= hot;
      buck_ready <= rdy;
      #1;
   endtask : pins
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : finish_test

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_phase;
      int n;
      for (int i = 0; i < 130 && phase_start[0] !== 1'b1; i++) cyc(1);
      n = 0;
      do
      begin
         cyc(1);
         n++;
      end
      while (phase_start[1] !== 1'b1 && n < 130);
      chk("phase_gap", 8'h29, 8'(n));
   endtask : t_phase
   task automatic t_restart;
      tbsfs_host_model_inst.issue(0);
      wait_st(tbsfs_pkg::TBSFS_ST_STARTUP, 4);
      wait_en(3'h3, 40);
      tbsfs_host_model_inst.issue(0);
      wait_en(3'h1, 8);
      wait_st(tbsfs_pkg::TBSFS_ST_ACTIVE, 100);
   endtask : t_restart
   task automatic t_sleep;
      tbsfs_host_model_inst.issue(1);
      wait_st(tbsfs_pkg::TBSFS_ST_SLEEP, 3);
      outs(3'h6, 1'b1);
      tbsfs_host_model_inst.issue(2);
      wait_st(tbsfs_pkg::TBSFS_ST_ACTIVE, 3);
      chk("load_defaults", 8'h01, 8'(ctrl.load_defaults));
      outs(3'h7, 1'b1);
      tbsfs_host_model_inst.issue(1);
      tbsfs_host_model_inst.issue(0);
      wait_st(tbsfs_pkg::TBSFS_ST_STARTUP, 4);
      wait_st(tbsfs_pkg::TBSFS_ST_ACTIVE, 100);
   endtask : t_sleep
   task automatic t_shut;
      tbsfs_host_model_inst.issue(3);
      wait_st(tbsfs_pkg::TBSFS_ST_SHUTDOWN, 3);
      outs(3'h0, 1'b0);
      pins(1'b0, 1'b0, 1'b0, 3'h7);
      cyc(4);
      tbsfs_host_model_inst.issue(0);
      cyc(2);
      chk("state", 8'h03, 8'(state));
      pins(1'b1, 1'b0, 1'b0, 3'h7);
      wait_st(tbsfs_pkg::TBSFS_ST_STARTUP, 6);
      wait_st(tbsfs_pkg::TBSFS_ST_ACTIVE, 100);
      tbsfs_host_model_inst.issue(1);
      tbsfs_host_model_inst.issue(3);
      wait_st(tbsfs_pkg::TBSFS_ST_SHUTDOWN, 3);
      tbsfs_host_model_inst.issue(0);
      wait_st(tbsfs_pkg::TBSFS_ST_STARTUP, 3);
      wait_st(tbsfs_pkg::TBSFS_ST_ACTIVE, 100);
   endtask : t_shut
   task automatic t_enable;
      pins(1'b0, 1'b0, 1'b0, 3'h7);
      wait_st(tbsfs_pkg::TBSFS_ST_STARTUP, 6);
      outs(3'h0, 1'b0);
      tbsfs_host_model_inst.issue(3);
      cyc(3);
      chk("state", 8'h00, 8'(state));
      pins(1'b1, 1'b0, 1'b0, 3'h7);
      wait_st(tbsfs_pkg::TBSFS_ST_ACTIVE, 100);
   endtask : t_enable
   task automatic t_ready;
      pins(1'b1, 1'b0, 1'b0, 3'h3);
      cyc(10);
      pins(1'b1, 1'b0, 1'b0, 3'h7);
      cyc(20);
      chk("state", 8'h01, 8'(state));
      pins(1'b1, 1'b0, 1'b0, 3'h0);
      wait_en(3'h0, 30);
      outs(3'h0, 1'b0);
      wait_en(3'h7, 200);
      wait_en(3'h0, 60);
      pins(1'b1, 1'b0, 1'b0, 3'h7);
      wait_st(tbsfs_pkg::TBSFS_ST_ACTIVE, 400);
   endtask : t_ready
   task automatic t_fault(input logic hot);
      pins(1'b1, !hot, hot, 3'h7);
      cyc(8);
      chk("sw_hiz", 8'h07, 8'(ctrl.sw_hiz));
      chk("fb_pulldown", 8'(!hot), 8'(ctrl.fb_pulldown));
      outs(3'h0, 1'b0);
      chk("state", 8'h00, 8'(state));
      pins(1'b1, 1'b0, 1'b0, 3'h7);
      wait_st(tbsfs_pkg::TBSFS_ST_ACTIVE, 100);
   endtask : t_fault

   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      finish_test;
   end
   initial
   begin
      n_mismatch = 0;
      n_checks = 0;
      rst_n = 1'b0;
      enable_pin = 1'b1;
      undervolt_lockout = 1'b0;
      over_temp = 1'b0;
      buck_ready = 3'h7;
      cyc(4);
      outs(3'h0, 1'b0);
      chk("state", 8'h00, 8'(state));
      @(posedge ref_clk);
      rst_n <= 1'b1;
      wait_en(3'h7, 40);
      wait_st(tbsfs_pkg::TBSFS_ST_ACTIVE, 60);
      outs(3'h7, 1'b1);
      t_phase;
      t_restart;
      t_sleep;
      t_shut;
      t_enable;
      t_ready;
      t_fault(1'b0);
      t_fault(1'b1);
      finish_test;
   end
endmodule : testbench
